/* hdl/static_table_defines.vh */
/*
 * Constants for the static address table: register offsets, field positions,
 * control codes and reset values. Assumes inclusion by bare name.
 */
`ifndef STATIC_TABLE_DEFINES_VH
`define STATIC_TABLE_DEFINES_VH

// ============================================================
// Register indexes (byte address = 4 * index)
`define REG_CTRL_IDX        8'd110
`define REG_ADDR_HI_IDX     8'd110
`define REG_ADDR_LO_IDX     8'd111
`define REG_DATA0_IDX       8'd113
`define REG_DATA7_IDX       8'd120
`define REG_STATUS_IDX      8'd121

// ============================================================
// Control register fields
`define CTRL_FUNC_HI        7
`define CTRL_FUNC_LO        5
`define CTRL_READ_BIT       4
`define CTRL_TSEL_HI        3
`define CTRL_TSEL_LO        2
`define FUNC_TABLE          3'h0
`define TSEL_STATIC         2'h0

// ============================================================
// Entry layout, read view
`define RD_GID_HI           63
`define RD_GID_LO           57
`define RD_USE_GID          56
`define RD_RSVD             55
// Entry layout, write view
`define WR_GID_HI           62
`define WR_GID_LO           56
`define WR_USE_GID          55
// Common fields
`define ENT_OVERRIDE        54
`define ENT_VALID           53
`define ENT_PORTS_HI        52
`define ENT_PORTS_LO        48
`define ENT_MAC_HI          47
`define ENT_MAC_LO          0

// ============================================================
// Reset values, bus responses and the all-ports mask
`define CTRL_RESET          8'h00
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define ALL_PORTS           5'h1f

`endif

/* hdl/static_mac_address_table.v */
/*
 * Static address table: 32 entries, indirect access over AXI4-Lite, and a
 * combinational destination/source search, registered one cycle later, whose static hit replaces the dynamic result on destination lookups.
 * Assumes a dynamic table answering in the same cycle as the lookup request.
 */
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`include "static_table_defines.vh"

module static_mac_address_table #(
	parameter ENTRIES = 32,
	parameter IDX_W   = 5
) (
	input  wire        clk,
	input  wire        reset,
	input  wire [9:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [9:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        lookup_req,
	input  wire        lookup_is_da,
	input  wire [47:0] lookup_mac,
	input  wire [6:0]  lookup_group_id,
	input  wire [2:0]  ingress_port,
	input  wire        dyn_hit,
	input  wire [4:0]  dyn_ports,
	output reg         fwd_valid,
	output reg         fwd_hit,
	output reg         fwd_static,
	output reg  [4:0]  fwd_ports,
	output reg         fwd_override,
	output wire        dyn_search
);

	// ============================================================
	// Storage, written only from the indirect port
	// Each entry lives in its own generate branch; these nets only fan it out
	wire [6:0]  gid     [0:ENTRIES-1];
	wire        use_gid [0:ENTRIES-1];
	wire        ovr     [0:ENTRIES-1];
	wire        vld     [0:ENTRIES-1];
	wire [4:0]  ports   [0:ENTRIES-1];
	wire [47:0] mac     [0:ENTRIES-1];
	wire [ENTRIES-1:0] hit_vec;

	reg  [7:0]  ctrl;
	reg  [7:0]  addr_lo;
	reg  [63:0] data_buf;
	reg         last_ok;
	reg         aw_held;
	reg         w_held;
	reg  [9:0]  aw_q;
	reg  [31:0] w_q;
	reg  [3:0]  ws_q;

	// ============================================================
	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;

	wire        aw_now = aw_held || s_axi_awvalid;
	wire        w_now  = w_held || s_axi_wvalid;
	wire [9:0]  wa     = aw_held ? aw_q : s_axi_awaddr;
	wire [31:0] wd     = w_held ? w_q : s_axi_wdata;
	wire [3:0]  wsb    = w_held ? ws_q : s_axi_wstrb;
	wire        do_wr  = aw_now && w_now && !s_axi_bvalid;
	wire [7:0]  widx   = wa[9:2];
	wire        wr_ok  = widx == `REG_CTRL_IDX || widx == `REG_ADDR_LO_IDX ||
	                     (widx >= `REG_DATA0_IDX && widx <= `REG_DATA7_IDX);

	// Only byte lane 0 carries register data
	wire        lane0  = wsb[0];
	wire        is_static = ctrl[`CTRL_FUNC_HI:`CTRL_FUNC_LO] == `FUNC_TABLE &&
	                        ctrl[`CTRL_TSEL_HI:`CTRL_TSEL_LO] == `TSEL_STATIC;
	wire        trig   = do_wr && lane0 && widx == `REG_ADDR_LO_IDX;
	wire [IDX_W-1:0] tidx = wd[IDX_W-1:0];
	// Index above 31 falls outside the static range and is ignored
	wire        in_rng = wd[7:IDX_W] == 3'h0 && is_static;
	wire [2:0]  dsel   = widx[2:0] - 3'd1;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_q         <= 10'h000;
			w_q          <= 32'h00000000;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			// A new write cannot start while the response still stands
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_wr) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_q    <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_q    <= s_axi_wdata;
					ws_q   <= s_axi_wstrb;
				end
			end
		end
	end

	// ============================================================
	// Indirect registers and transfers
	wire        ctrl_we = do_wr && lane0 && widx == `REG_CTRL_IDX;
	wire        data_we = do_wr && lane0 && widx >= `REG_DATA0_IDX && widx <= `REG_DATA7_IDX;
	wire        rd_go   = trig && in_rng && ctrl[`CTRL_READ_BIT];
	wire        wr_go   = trig && in_rng && !ctrl[`CTRL_READ_BIT];
	// One-hot entry select keeps the per-entry compare free of index arithmetic
	wire [ENTRIES-1:0] wr_sel = wr_go ? ({{(ENTRIES-1){1'b0}}, 1'b1} << tidx) :
	                            {ENTRIES{1'b0}};
	// Read view keeps bit 55 at zero
	wire [63:0] rd_view = {gid[tidx], use_gid[tidx], 1'b0, ovr[tidx],
	                       vld[tidx], ports[tidx], mac[tidx]};

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl     <= `CTRL_RESET;
			addr_lo  <= 8'h00;
			data_buf <= 64'h0;
			last_ok  <= 1'b0;
		end else begin
			if (ctrl_we) begin
				ctrl <= wd[7:0];
			end
			if (data_we) begin
				data_buf[8*(7-dsel) +: 8] <= wd[7:0];
			end
			if (trig) begin
				addr_lo <= wd[7:0];
				last_ok <= in_rng;
			end
			// A read replaces the whole buffer, so software reloads before a write
			if (rd_go) begin
				data_buf <= rd_view;
			end
		end
	end

	// ============================================================
	// Entry storage and per-entry match
	genvar e;
	generate
		for (e = 0; e < ENTRIES; e = e + 1) begin : g_entry
			reg  [6:0]  e_gid;
			reg         e_use;
			reg         e_ovr;
			reg         e_vld;
			reg  [4:0]  e_ports;
			reg  [47:0] e_mac;

			// Written only from the indirect port; no aging path exists
			always @(posedge clk or posedge reset) begin
				if (reset) begin
					e_gid   <= 7'h00;
					e_use   <= 1'b0;
					e_ovr   <= 1'b0;
					e_vld   <= 1'b0;
					e_ports <= 5'h00;
					e_mac   <= 48'h0;
				end else if (wr_sel[e]) begin
					e_gid   <= data_buf[`WR_GID_HI:`WR_GID_LO];
					e_use   <= data_buf[`WR_USE_GID];
					e_ovr   <= data_buf[`ENT_OVERRIDE];
					e_vld   <= data_buf[`ENT_VALID];
					e_ports <= data_buf[`ENT_PORTS_HI:`ENT_PORTS_LO];
					e_mac   <= data_buf[`ENT_MAC_HI:`ENT_MAC_LO];
				end
			end

			assign gid[e]     = e_gid;
			assign use_gid[e] = e_use;
			assign ovr[e]     = e_ovr;
			assign vld[e]     = e_vld;
			assign ports[e]   = e_ports;
			assign mac[e]     = e_mac;

			// Group compare only counts when the entry asks for it
			assign hit_vec[e] = e_vld && e_mac == lookup_mac &&
			                    (!e_use || e_gid == lookup_group_id);
		end
	endgenerate
	// entries change only through wr_sel above and reset

	// ============================================================
	// Read channel, one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;
	wire [7:0] ridx = s_axi_araddr[9:2];
	wire [2:0] rsel = ridx[2:0] - 3'd1;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			s_axi_rdata  <= 32'h00000000;
			case (ridx)
				`REG_CTRL_IDX: begin
					s_axi_rdata <= {24'h0, ctrl};
				end
				`REG_ADDR_LO_IDX: begin
					s_axi_rdata <= {24'h0, addr_lo};
				end
				`REG_STATUS_IDX: begin
					s_axi_rdata <= {31'h0, last_ok};
				end
				default: begin
					// Data bytes share one decode; anything else is unmapped
					if (ridx >= `REG_DATA0_IDX && ridx <= `REG_DATA7_IDX) begin
						s_axi_rdata <= {24'h0, data_buf[8*(7-rsel) +: 8]};
					end else begin
						s_axi_rresp <= `RESP_SLVERR;
					end
				end
			endcase
		end
	end

	// ============================================================
	// Lookup: priority search, lowest index wins
	reg             s_hit;
	reg [IDX_W-1:0] s_idx;
	integer j;
	always @* begin
		s_hit = 1'b0;
		s_idx = {IDX_W{1'b0}};
		// Walk downwards so the lowest matching index is left standing
		for (j = ENTRIES - 1; j >= 0; j = j - 1) begin
			if (hit_vec[j]) begin
				s_hit = 1'b1;
				s_idx = j[IDX_W-1:0];
			end
		end
	end

	// Source lookups must never see a static result
	assign dyn_search = lookup_req;
	wire        use_static = lookup_req && lookup_is_da && s_hit;
	reg  [4:0]  ingress_bit;
	always @* begin
		case (ingress_port)
			3'd1:    ingress_bit = 5'h01;
			3'd2:    ingress_bit = 5'h02;
			3'd3:    ingress_bit = 5'h04;
			3'd4:    ingress_bit = 5'h08;
			3'd5:    ingress_bit = 5'h10;
			// No such port: nothing to exclude
			default: ingress_bit = 5'h00;
		endcase
	end

	// all ones means every port except ingress
	wire [4:0]  s_ports = ports[s_idx] == `ALL_PORTS ?
	                      (`ALL_PORTS & ~ingress_bit) : ports[s_idx];

	// Static result replaces the dynamic one outright, never merged
	reg         next_fwd_hit;
	reg  [4:0]  next_fwd_ports;
	always @* begin
		next_fwd_hit   = 1'b0;
		next_fwd_ports = 5'h00;
		if (use_static) begin
			next_fwd_hit   = 1'b1;
			next_fwd_ports = s_ports;
		end else if (lookup_req && dyn_hit) begin
			next_fwd_hit   = 1'b1;
			next_fwd_ports = dyn_ports;
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			fwd_valid    <= 1'b0;
			fwd_hit      <= 1'b0;
			fwd_static   <= 1'b0;
			fwd_ports    <= 5'h00;
			fwd_override <= 1'b0;
		end else begin
			fwd_valid    <= lookup_req;
			fwd_static   <= use_static;
			fwd_hit      <= next_fwd_hit;
			fwd_ports    <= next_fwd_ports;
			fwd_override <= use_static && ovr[s_idx];
		end
	end

endmodule // static_mac_address_table

/* test/static_table_assertions.sv */
/*
 * Checker for the static address table top module ports.
 * Assumes one clock domain, clk, and the asynchronous high reset.
 */
module static_table_checker (
	input wire        clk,
	input wire        reset,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        lookup_req,
	input wire        lookup_is_da,
	input wire        dyn_hit,
	input wire [4:0]  dyn_ports,
	input wire        fwd_valid,
	input wire        fwd_hit,
	input wire        fwd_static,
	input wire [4:0]  fwd_ports,
	input wire        fwd_override,
	input wire        dyn_search
);
	// ============================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_answer; lookup_req |=> fwd_valid; endproperty
	a_answer: assert property (p_answer) else $error("lookup not answered");
	property p_no_stray; fwd_valid |-> $past(lookup_req); endproperty
	a_no_stray: assert property (p_no_stray) else $error("stray result");
	property p_search; dyn_search == lookup_req; endproperty
	a_search: assert property (p_search) else $error("dynamic search mismatch");
	property p_sa_dyn; lookup_req && !lookup_is_da |=> !fwd_static && fwd_hit == $past(dyn_hit)
		&& fwd_ports == $past(dyn_ports); endproperty
	a_sa_dyn: assert property (p_sa_dyn) else $error("source lookup used static");
	property p_da_hit; lookup_req && lookup_is_da && dyn_hit |=> fwd_hit; endproperty
	a_da_hit: assert property (p_da_hit) else $error("dynamic hit lost");
	property p_static_hit; fwd_static |-> fwd_hit && fwd_valid; endproperty
	a_static_hit: assert property (p_static_hit) else $error("static without hit");
	property p_override; fwd_override |-> fwd_static; endproperty
	a_override: assert property (p_override) else $error("override without static");
	property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read response dropped");
	property p_r_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_r_byte: assert property (p_r_byte) else $error("upper read bits set");
endmodule // static_table_checker
bind static_mac_address_table static_table_checker i_static_table_checker (.*);

/* test/dyn_table_model.sv */
/*
 * Dynamic table stand-in: answers in the lookup cycle for two addresses.
 * Assumes the lookup address is held for the request cycle.
 */
module dyn_table_model #(
	parameter [47:0] MAC_A = 48'h000000000001,
	parameter [47:0] MAC_C = 48'h000000000002
) (
	input  wire [47:0] lookup_mac,
	output wire        dyn_hit,
	output wire [4:0]  dyn_ports
);
	// Miss drives zero ports so a stale value cannot leak through
	assign dyn_hit = (lookup_mac == MAC_A) || (lookup_mac == MAC_C);
	assign dyn_ports = (lookup_mac == MAC_A) ? 5'h08 : (lookup_mac == MAC_C) ? 5'h02 : 5'h00;
endmodule // dyn_table_model

/* test/tb.sv */
/*
 * Self-checking bench: entries go in and out over AXI4-Lite, then lookups.
 * Assumes responses always accepted, so bready and rready stay high.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [47:0] MA = 48'h021122334455, MB = 48'h02aabbccdd01, MC = 48'h02aabbccdd02;
	typedef struct packed {logic da; logic [47:0] mac; logic [6:0] gid; logic [2:0] ing;
		logic hit; logic st; logic [4:0] ports; logic ovr;} row_t;
	logic clk = 1'b0, reset = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, lookup_req = 1'b0, lookup_is_da = 1'b0;
	logic [9:0] s_axi_awaddr = 10'h000; logic [9:0] s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0; logic [3:0] s_axi_wstrb = 4'h1;
	logic [47:0] lookup_mac = 48'h0; logic [6:0] lookup_group_id = 7'h00; logic [2:0] ingress_port = 3'h1;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dyn_hit;
	wire fwd_valid, fwd_hit, fwd_static, fwd_override, dyn_search;
	wire [1:0] s_axi_bresp, s_axi_rresp; wire [31:0] s_axi_rdata; wire [4:0] dyn_ports, fwd_ports;
	int bad_count = 0, n_checks = 0;
	logic [63:0] e; logic [1:0] r;
	row_t rows [5] = '{'{1, MA, 0, 1, 1, 1, 5'h06, 1}, '{0, MA, 0, 1, 1, 0, 5'h08, 0},
		'{1, MB, 5, 3, 1, 1, 5'h1b, 0}, '{1, MB, 6, 3, 0, 0, 5'h00, 0}, '{1, MC, 0, 2, 1, 0, 5'h02, 0}};
	static_mac_address_table i_static_mac_address_table (.*);
	dyn_table_model #(.MAC_A(MA), .MAC_C(MC)) i_dyn_table_model (.*);
	always #5 clk = ~clk;
	// ============================================================
	// Report, compare and bus tasks
	task report_and_stop; if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]"); $finish; endtask
	task cmp(input logic [63:0] got, input logic [63:0] exp); n_checks++;
		if (got !== exp) begin bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp); end endtask
	task wr(input int idx, input logic [7:0] d, output logic [1:0] rsp);
		logic ad, wd;
		ad = 1; wd = 1; s_axi_awaddr <= 10'(4 * idx); s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
		while (ad || wd) begin @(posedge clk);
			if (ad && s_axi_awready === 1'b1) begin ad = 0; s_axi_awvalid <= 1'b0; end
			if (wd && s_axi_wready === 1'b1) begin wd = 0; s_axi_wvalid <= 1'b0; end end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp; endtask
	task rd(input int idx, output logic [7:0] d);
		s_axi_araddr <= 10'(4 * idx); s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[7:0];
		cmp(s_axi_rresp, 2'h0);
	endtask
	// Whole entry, most significant byte first, then control and trigger
	task put(input int idx, input logic [63:0] v); logic [1:0] q;
		for (int i = 0; i < 8; i++) wr(113 + i, v[63 - 8 * i -: 8], q);
		wr(110, 8'h00, q); wr(111, 8'(idx), q); endtask
	task get(input int idx, output logic [63:0] v); logic [1:0] q; logic [7:0] d;
		wr(110, 8'h10, q); wr(111, 8'(idx), q);
		for (int i = 0; i < 8; i++) begin rd(113 + i, d); v[63 - 8 * i -: 8] = d; end endtask
	// ============================================================
	// Sequence
	initial begin #200000; bad_count++; report_and_stop; end
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		get(0, e); cmp(e, 64'h0);
		put(0, {1'b0, 7'h00, 1'b0, 1'b1, 1'b1, 5'h06, MA});
		put(1, {1'b1, 7'h05, 1'b1, 1'b0, 1'b1, 5'h1f, MB});
		put(2, {1'b0, 7'h00, 1'b0, 1'b0, 1'b1, 5'h10, MA});
		put(3, {1'b0, 7'h00, 1'b0, 1'b0, 1'b0, 5'h01, MC});
		foreach (rows[k]) begin
			lookup_req <= 1'b1; lookup_is_da <= rows[k].da; lookup_mac <= rows[k].mac;
			lookup_group_id <= rows[k].gid; ingress_port <= rows[k].ing;
			@(posedge clk); lookup_req <= 1'b0; #1;
			cmp(fwd_valid, 1'b1);
			cmp({fwd_hit, fwd_static, fwd_ports, fwd_override}, rows[k][7:0]);
			@(posedge clk); end
		wr(60, 8'h00, r); cmp(r, 2'h2);
		get(1, e); cmp(e, {7'h05, 1'b1, 1'b0, 1'b0, 1'b1, 5'h1f, MB});
		// Mid-run reset clears every entry
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		get(1, e); cmp(e, 64'h0);
		report_and_stop;
	end
endmodule // tb
